// >>> bench/mem_model.sv
// Purpose: Little-endian byte memory answering the downstream bus.
// Assumes: Read data returned in address byte lanes.
// Notes: Data lines are inverted when no answer stands.
`timescale 1ns/1ps
module mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic memValid,
   input wire logic memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [2:0] memSize,
   input wire logic [31:0] memWdata,
   input wire logic [2:0] delay,
   input wire logic errOn,
   input wire logic [31:0] errAddr,
   output logic memReady,
   output logic memErr,
   output logic [31:0] memRdata
);
   logic [7:0] mem [256];
   logic [31:0] log [$];
   logic [7:0] a;
   int cnt;
   assign a = memAddr[7:0];
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         memReady <= 1'b0;
         memErr <= 1'b0;
         memRdata <= 32'h0;
         cnt <= 0;
      end else if (memReady) begin
         memReady <= 1'b0;
         memErr <= 1'b0;
         memRdata <= ~memRdata;
      end else if (memValid && cnt < delay) begin
         cnt <= cnt + 1;
      end else if (memValid) begin
         cnt <= 0;
         memReady <= 1'b1;
         memErr <= errOn && memAddr == errAddr;
         memRdata <= {mem[{a[7:2], 2'h3}], mem[{a[7:2], 2'h2}], mem[{a[7:2], 2'h1}], mem[{a[7:2], 2'h0}]};
         log.push_back(memAddr);
         if (memWrite && !(errOn && memAddr == errAddr))
            for (int i = 0; i < (1 << memSize); i++) mem[8'(a + i)] <= memWdata[8 * ((a + i) % 4) +: 8];
      end
   end
endmodule // mem_model

// >>> bench/packed_mem_access_chk.sv
// Purpose: Port assertions for the packed memory access port.
// Assumes: Hand-over timing: one-cycle pready, memValid held until memReady.
// Notes: Only the own-port error path is tied to pslverr.
`timescale 1ns/1ps
`include "packed_map.svh"
module packed_mem_access_chk #(
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic memValid,
   input wire logic memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [2:0] memSize,
   input wire logic memReady,
   input wire logic memErr,
   input wire logic slvValid,
   input wire logic slvReady
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_accept;
      memValid && memReady;
   endsequence
   sequence s_err;
      memValid && memReady && memErr && !slvValid;
   endsequence
   sequence s_drw_start;
      psel && penable && !$past(penable) && paddr == `OFF_DRW;
   endsequence
   a_valid_hold: assert property (memValid && !memReady |=> memValid && $stable(memAddr) && $stable(memSize) && $stable(memWrite)) else $error("request moved while waiting");
   a_valid_drop: assert property (s_accept |=> !memValid) else $error("valid held after accept");
   // Own-port accesses always run under a held APB access, so an open access without psel is the slave's.
   a_bit31_low: assert property (memValid && !psel |-> !memAddr[31]) else $error("address bit 31 set");
   a_err_stop: assert property (s_err |=> !memValid [*2]) else $error("access issued after error");
   a_err_reply: assert property (s_err |-> ##[1:4] (pready && pslverr)) else $error("error not returned");
   a_drw_wait: assert property (s_drw_start |=> !pready [*2]) else $error("data answer too early");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
   a_err_pair: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_quiet_reply: assert property (pready && paddr == `OFF_DRW |-> !memValid) else $error("answer while access open");
   a_slv_reply: assert property (slvReady |-> $past(memValid && memReady)) else $error("slave answer without access");
endmodule // packed_mem_access_chk
bind packed_mem_access packed_mem_access_chk #(.ADDR_W(ADDR_W)) chk (.clk(clk), .rstn(rstn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .memValid(memValid),
   .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize), .memReady(memReady), .memErr(memErr),
   .slvValid(slvValid), .slvReady(slvReady));

// >>> bench/tb_packed_mem_access.sv
// Purpose: Self-checking bench of the packed memory access port.
// Assumes: Memory model with random answer delay.
// Notes: Expected bytes come from a bench copy of memory.
`timescale 1ns/1ps
`include "packed_map.svh"
module tb_packed_mem_access;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, memValid, memWrite, memReady, memErr;
   logic slvValid, slvWrite, slvReady, slvErr, errOn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, slvAddr, slvWdata, slvRdata, errAddr, transfer_address_reg, rnd, r;
   logic [2:0] memSize, slvSize, delay;
   logic [7:0] bmem [256];
   logic e;
   int fail_count, checks_done, cyc, incOn;
   packed_mem_access #(.ADDR_W(12)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memValid(memValid),
      .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize), .memWdata(memWdata), .memReady(memReady),
      .memErr(memErr), .memRdata(memRdata), .slvValid(slvValid), .slvWrite(slvWrite), .slvAddr(slvAddr),
      .slvSize(slvSize), .slvWdata(slvWdata), .slvReady(slvReady), .slvErr(slvErr), .slvRdata(slvRdata));
   mem_model mm (.clk(clk), .rstn(rstn), .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr),
      .memSize(memSize), .memWdata(memWdata), .delay(delay), .errOn(errOn), .errAddr(errAddr),
      .memReady(memReady), .memErr(memErr), .memRdata(memRdata));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic final_report();
      $display("counts: checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic cfg(input int s, input int inc, input logic [31:0] base);
      apb(1, `OFF_CSW, 32'(s) | 32'(inc << `CSW_INC_LSB));
      apb(1, `OFF_TAR, base);
      transfer_address_reg = base;
      incOn = inc;
   endtask
   task automatic data_read_write_reg(input logic w, input int n, input int sz, input int errIdx);
      int k;
      logic [7:0] a;
      logic [31:0] x;
      k = (errIdx < n) ? errIdx + 1 : n;
      x = 0;
      mm.log.delete();
      rnd = lfsr(rnd);
      delay <= rnd[6:4];
      apb(w, `OFF_DRW, rnd);
      check(mm.log.size(), k);
      for (int i = 0; i < k; i++) begin
         a = 8'(transfer_address_reg + i * sz);
         check(mm.log[i], transfer_address_reg + i * sz);
         for (int b = 0; b < sz; b++) begin
            if (w && i < errIdx) bmem[8'(a + b)] = rnd[8 * ((a + b) % 4) +: 8];
            x[8 * ((a + b) % 4) +: 8] = bmem[8'(a + b)];
         end
      end
      check(e, errIdx < n);
      if (!w && errIdx >= n) check(r, x);
      if (incOn != 0) transfer_address_reg = transfer_address_reg + sz * (k - (errIdx < n));
      apb(0, `OFF_TAR, 0);
      check(r, transfer_address_reg);
   endtask
   task automatic slv(input logic w, input logic [31:0] d);
      @(posedge clk);
      {slvValid, slvWrite, slvAddr, slvSize, slvWdata} <= {1'b1, w, 32'h8000_0070, `SIZE_WORD, d};
      do @(posedge clk); while (slvReady !== 1'b1);
      r = slvRdata;
      e = slvErr;
      slvValid <= 1'b0;
   endtask
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, slvValid, slvWrite, slvAddr, slvSize, slvWdata} = 0;
      {delay, errOn, errAddr, transfer_address_reg} = 0;
      rnd = 32'd70;
      for (int i = 0; i < 256; i++) bmem[i] = 8'(i) ^ 8'h5a;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      apb(0, `OFF_CSW, 0);
      check(r, `CSW_RESET);
      apb(0, `OFF_STAT, 0);
      check(r, 0);
      apb(0, 12'h008, 0);
      check(e, 1);
      $display("TEST reset and map done");
      for (int s = 0; s < 3; s++) begin
         cfg(s, `INC_PACKED, (s == 2) ? 32'h40 : 32'h42);
         data_read_write_reg(1, 4 >> s, 1 << s, 9);
         data_read_write_reg(1, 4 >> s, 1 << s, 9);
         cfg(s, `INC_PACKED, (s == 2) ? 32'h40 : 32'h42);
         data_read_write_reg(0, 4 >> s, 1 << s, 9);
         data_read_write_reg(0, 4 >> s, 1 << s, 9);
         $display("TEST packed size %0d done", s);
      end
      cfg(0, `INC_PACKED, 32'h60);
      errOn <= 1'b1;
      errAddr <= 32'h61;
      data_read_write_reg(1, 4, 1, 1);
      errOn <= 1'b0;
      apb(0, `OFF_STAT, 0);
      check(r[`STAT_ERR_BIT], 1);
      apb(1, `OFF_STAT, 32'h2);
      apb(0, `OFF_STAT, 0);
      check(r, 0);
      $display("TEST error stop done");
      cfg(0, `INC_OFF, 32'h81);
      apb(1, `OFF_CNT, 32'h2);
      data_read_write_reg(1, 1, 1, 9);
      apb(0, `OFF_CNT, 0);
      check(r, 32'h1);
      cfg(1, `INC_SINGLE, 32'h92);
      data_read_write_reg(1, 1, 2, 9);
      $display("TEST unpacked access done");
      mm.log.delete();
      rnd = lfsr(rnd);
      slv(1, rnd);
      for (int b = 0; b < 4; b++) bmem[8'h70 + b] = rnd[8 * b +: 8];
      check(mm.log[0], 32'h70);
      check(e, 0);
      slv(0, 0);
      check(r, rnd);
      $display("TEST slave port done");
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      apb(0, `OFF_TAR, 0);
      check(r, 0);
      apb(0, `OFF_CSW, 0);
      check(r, `CSW_RESET);
      $display("TEST mid-run reset done");
      final_report();
   end
endmodule // tb_packed_mem_access

// >>> core/lane_steer.sv
// Purpose: Little-endian byte-lane steering between the data word and a sub-word access.
// Assumes: Size codes byte, halfword, word.
// Notes: Write lanes registered; read merge combinational.
`timescale 1ns/1ps
`include "packed_map.svh"
module lane_steer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] size,
   input wire logic [1:0] addrLow,
   input wire logic [31:0] word,
   input wire logic [31:0] busRdata,
   output logic [31:0] wrLanes,
   output logic [31:0] rdMerged
);
   logic [31:0] mask;
   always_comb begin
      case (size)
         `SIZE_BYTE: mask = 32'h0000_00ff << {addrLow, 3'h0};
         `SIZE_HALF: mask = addrLow[1] ? 32'hffff_0000 : 32'h0000_ffff;
         default: mask = 32'hffff_ffff;
      endcase
   end
   // Only the selected lanes of the word are driven on the bus, others zero; the strobe-free target picks its lane by address.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrLanes <= 32'h0;
      end else begin
         wrLanes <= word & mask;
      end
   end
   always_comb rdMerged = (word & ~mask) | (busRdata & mask);
endmodule // lane_steer

// >>> core/packed_map.svh
// Purpose: Offsets, field positions, codes and reset values of the packed memory access port.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Included by every design file of the block except the type package.
`ifndef PACKED_MAP_SVH
`define PACKED_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_CSW 12'h000
`define OFF_TAR 12'h004
`define OFF_DRW 12'h00c
`define OFF_CNT 12'h010
`define OFF_STAT 12'h014
// ----------------------------------------------------------------------------
// Control and status word fields and codes
// ----------------------------------------------------------------------------
`define CSW_SIZE_LSB 0
`define CSW_INC_LSB 4
`define SIZE_BYTE 3'h0
`define SIZE_HALF 3'h1
`define SIZE_WORD 3'h2
`define INC_OFF 2'h0
`define INC_SINGLE 2'h1
`define INC_PACKED 2'h2
`define CSW_RESET 32'h0000_0002
`define CSW_WMASK 32'h0000_0037
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`endif

// >>> core/packed_mem_access.sv
// Purpose: APB-programmed memory access port that splits data accesses into packed sub-word bus accesses.
// Assumes: Downstream bus is valid/ready with an error flag; slave port shares it.
// Notes: Slave port requests are served only while no packed sequence runs.
//
// Behaviour
// - Packing happens only when increment mode holds the packed code.
// - Packed word size gives one 32-bit memory access.
// - Packed halfword size gives two 16-bit accesses.
// - Packed byte size gives four 8-bit accesses.
// - Each successful access adds the size in bytes to the address, unless increment mode is off.
// - Accesses of one packed sequence go in ascending address order.
// - Write data comes from the lane picked by the low address bits.
// - Read data lands in the lane picked by the low address bits.
// - An error stops the sequence and returns an error.
// - A packed read completes only once the whole word is filled.
// - A nonzero counter counts down by one at the end of each data access sequence.
// - A slave memory port lets an outside master reach the memory.
// - Slave port accesses share the downstream bus.
// - Slave port accesses have address bit 31 forced to zero.
// - Lowest-addressed lane is the least significant byte of the word.
// - Size codes are byte 000, halfword 001, word 010.
`timescale 1ns/1ps
`include "packed_map.svh"
module packed_mem_access
   import packed_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic memValid,
   output logic memWrite,
   output logic [31:0] memAddr,
   output logic [2:0] memSize,
   output logic [31:0] memWdata,
   input wire logic memReady,
   input wire logic memErr,
   input wire logic [31:0] memRdata,
   input wire logic slvValid,
   input wire logic slvWrite,
   input wire logic [31:0] slvAddr,
   input wire logic [2:0] slvSize,
   input wire logic [31:0] slvWdata,
   output logic slvReady,
   output logic slvErr,
   output logic [31:0] slvRdata
);
   // ----------------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------------
   // The register map reaches offset 0x14, so fewer address bits would alias registers.
   // Offsets are compared on twelve bits; address bits above bit 11 are ignored.
   if (ADDR_W < 5) begin : g_addrCheck
      $error("ADDR_W too small for the register map");
   end

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   logic [31:0] csw_q;
   logic [31:0] tar_q;
   logic [31:0] drw_q;
   logic [7:0] cnt_q;
   logic err_q;
   seq_state_t state_q;
   // Tells whose access is open on the downstream bus.
   grant_t grant_q;
   // Bus accesses still to be made in the running sequence.
   logic [2:0] left_q;
   logic seqWrite_q;
   logic [31:0] rdMerged;

   // Bytes moved by one bus access; codes above word count as a word.
   function automatic logic [31:0] sizeBytes(input logic [2:0] s);
      case (s)
         `SIZE_BYTE: sizeBytes = 32'h1;
         `SIZE_HALF: sizeBytes = 32'h2;
         default: sizeBytes = 32'h4;
      endcase
   endfunction

   // Bus accesses made for one data access; packing with sizes above word falls back to one.
   function automatic logic [2:0] accessCount(input logic [2:0] s, input logic packed_en);
      if (!packed_en) accessCount = 3'h1;
      else begin
         case (s)
            `SIZE_BYTE: accessCount = 3'h4;
            `SIZE_HALF: accessCount = 3'h2;
            default: accessCount = 3'h1;
         endcase
      end
   endfunction

   logic [2:0] sizeField;
   logic [1:0] incMode;
   logic packedOn;
   assign sizeField = csw_q[`CSW_SIZE_LSB +: 3];
   assign incMode = csw_q[`CSW_INC_LSB +: 2];
   // Any other increment code gives plain transfers of one access each.
   assign packedOn = (incMode == `INC_PACKED);

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   logic [11:0] offs;
   logic access;
   logic isDrw;
   logic mapped;
   assign offs = 12'(paddr);
   assign access = psel && penable;
   assign isDrw = (offs == `OFF_DRW);
   // Offsets outside the map are answered at once with pslverr and zero data.
   assign mapped = (offs == `OFF_CSW) || (offs == `OFF_TAR) || isDrw || (offs == `OFF_CNT) || (offs == `OFF_STAT);

   // The slave port owns the bus until its single access has been answered.
   function automatic logic slvBusy();
      slvBusy = (grant_q == SLAVE_PORT);
   endfunction

   // A sequence starts once, on the first access cycle in which the slave port does not own the bus; the raised pready blocks a restart.
   logic startSeq;
   assign startSeq = access && isDrw && (state_q == IDLE) && !pready && !slvBusy();

   // ----------------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------------
   logic busDone;
   assign busDone = memValid && memReady;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IDLE;
         left_q <= 3'h0;
         seqWrite_q <= 1'b0;
      end else begin
         case (state_q)
            // The direction is kept for the whole sequence, as the master may move on once answered.
            IDLE: begin
               if (startSeq) begin
                  state_q <= ISSUE;
                  left_q <= accessCount(sizeField, packedOn);
                  seqWrite_q <= pwrite;
               end
            end
            // One cycle in ISSUE lets the address settle after the previous increment before launch.
            ISSUE: state_q <= WAIT;
            WAIT: begin
               if (busDone && grant_q == OWN_PORT) begin
                  // An error ends the sequence at once, so no later lane is touched.
                  if (memErr || left_q == 3'h1) begin
                     state_q <= DONE;
                  end else begin
                     state_q <= ISSUE;
                     left_q <= left_q - 3'h1;
                  end
               end
            end
            DONE: state_q <= IDLE;
            default: state_q <= IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Downstream bus and slave port mux
   // ----------------------------------------------------------------------------
   // A slave request is taken only between sequences, so it never splits a packed sequence.
   // The cost is that a slave request waits until the running data access sequence has reached IDLE again.
   logic slvLaunch;
   assign slvLaunch = !memValid && state_q == IDLE && !startSeq && slvValid && !slvReady;

   // Address, size and direction are loaded at launch and held until memReady.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         grant_q <= OWN_PORT;
         memValid <= 1'b0;
         memWrite <= 1'b0;
         memAddr <= 32'h0;
         memSize <= `SIZE_WORD;
         slvReady <= 1'b0;
         slvErr <= 1'b0;
         slvRdata <= 32'h0;
      end else begin
         slvReady <= 1'b0;
         if (busDone) begin
            memValid <= 1'b0;
            if (grant_q == SLAVE_PORT) begin
               slvReady <= 1'b1;
               slvErr <= memErr;
               slvRdata <= memRdata;
               grant_q <= OWN_PORT;
            end
         end else if (!memValid && state_q == ISSUE) begin
            memValid <= 1'b1;
            memWrite <= seqWrite_q;
            memAddr <= tar_q;
            memSize <= sizeField;
         end else if (slvLaunch) begin
            // Bit 31 is cleared so that targets can tell slave traffic from port traffic.
            grant_q <= SLAVE_PORT;
            memValid <= 1'b1;
            memWrite <= slvWrite;
            memAddr <= {1'b0, slvAddr[30:0]};
            memSize <= slvSize;
         end
      end
   end

   // The lane register drives the bus directly, so its inputs must already describe the access
   // launched at the same edge: slave data from the launch onwards, otherwise the data word.
   logic slvSide;
   logic [31:0] laneWord;
   logic [2:0] laneSize;
   assign slvSide = slvLaunch || grant_q == SLAVE_PORT;
   assign laneWord = slvSide ? slvWdata : drw_q;
   assign laneSize = (slvSide || !packedOn) ? `SIZE_WORD : sizeField;

   lane_steer u_lane (
      .clk(clk),
      .rstn(rstn),
      .size(laneSize),
      .addrLow(tar_q[1:0]),
      .word(laneWord),
      .busRdata(memRdata),
      .wrLanes(memWdata),
      .rdMerged(rdMerged)
   );

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   logic ownDone;
   assign ownDone = busDone && grant_q == OWN_PORT && state_q == WAIT;
   // Register writes wait while a sequence runs; they land as pready is decided.
   logic wrReg;
   assign wrReg = access && pwrite && !pready && state_q == IDLE;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         csw_q <= `CSW_RESET;
      end else if (wrReg && offs == `OFF_CSW) begin
         csw_q <= pwdata & `CSW_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tar_q <= 32'h0;
      end else if (wrReg && offs == `OFF_TAR) begin
         tar_q <= pwdata;
      // Only successful accesses advance the address, so after an error it names the failing one.
      end else if (ownDone && !memErr && incMode != `INC_OFF) begin
         tar_q <= tar_q + (packedOn ? sizeBytes(sizeField) : sizeBytes(memSize));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         drw_q <= 32'h0;
      end else if (startSeq && pwrite) begin
         drw_q <= pwdata;
      // Each returned lane is merged into the word; the master sees it only from DONE.
      end else if (ownDone && !seqWrite_q && !memErr) begin
         drw_q <= packedOn ? rdMerged : memRdata;
      end
   end

   // Counter: a nonzero value counts down by one as each data access sequence reaches DONE.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h0;
      end else if (wrReg && offs == `OFF_CNT) begin
         cnt_q <= pwdata[7:0];
      end else if (state_q == DONE && cnt_q != 8'h0) begin
         cnt_q <= cnt_q - 8'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         err_q <= 1'b0;
      // Set and clear never meet: clearing writes wait until the sequence is over.
      end else if (ownDone && memErr) begin
         err_q <= 1'b1;
      end else if (wrReg && offs == `OFF_STAT && pwdata[`STAT_ERR_BIT]) begin
         err_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------------------
   // Error of the running sequence only, cleared as a new one starts, so old errors never reach pslverr.
   logic seqErr_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) seqErr_q <= 1'b0;
      else if (startSeq) seqErr_q <= 1'b0;
      else if (ownDone && memErr) seqErr_q <= 1'b1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (access && !pready) begin
            // A data access is answered one cycle after DONE, with the bus already idle.
            if (isDrw) begin
               if (state_q == DONE) begin
                  pready <= 1'b1;
                  pslverr <= seqErr_q;
                  prdata <= drw_q;
               end
            end else if (state_q == IDLE) begin
               pready <= 1'b1;
               pslverr <= !mapped;
               case (offs)
                  `OFF_CSW: prdata <= csw_q;
                  `OFF_TAR: prdata <= tar_q;
                  `OFF_CNT: prdata <= {24'h0, cnt_q};
                  `OFF_STAT: prdata <= {30'h0, err_q, 1'b0};
                  default: prdata <= 32'h0;
               endcase
            end
         end
      end
   end
endmodule // packed_mem_access

// >>> core/packed_pkg.sv
// Purpose: Types shared by the packed memory access port.
// Assumes: Nothing beyond the map header.
// Notes: States carry no codes.
package packed_pkg;
   typedef enum logic [1:0] {IDLE, ISSUE, WAIT, DONE} seq_state_t;
   typedef enum logic [0:0] {OWN_PORT, SLAVE_PORT} grant_t;
endpackage
